// ===== shared/pfc_pkg.sv
package pfc_pkg;

  // ==========================================================================
  // clocking
  // ==========================================================================
  localparam int CORE_CLK_HZ    = 20_000_000;
  localparam int CORE_PERIOD_NS = 50;
  localparam int LINK_MAX_HZ    = 40_000_000;
  // core cycles per half period of the link clock
  localparam int LINK_DIV_DEF   = 1;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int FLASH_DATA_W = 16;
  localparam int FLASH_ADDR_W = 24;
  localparam int CNT_W        = 8;
  localparam int CTRL_PIN_W   = 3;

  // ==========================================================================
  // flash timing, in ns and in core cycles
  // ==========================================================================
  localparam int RST_PULSE_NS   = 100;
  localparam int RST_RECOVER_NS = 150;
  localparam int ACCESS_NS      = 110;
  localparam int RST_PULSE_CYC   = (RST_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RST_RECOVER_CYC = (RST_RECOVER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int ACCESS_CYC      = (ACCESS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // three stages plus the agreement flop
  localparam int PIN_SYNC_LAT    = 4;
  localparam int READ_WAIT_CYC   = ACCESS_CYC + PIN_SYNC_LAT;

  // ==========================================================================
  // image layout
  // ==========================================================================
  localparam int                      IMAGE_WORDS_DEF = 1024;
  localparam logic [FLASH_ADDR_W-1:0] START_ADDR_DEF  = 24'h00_0000;

  // ==========================================================================
  // pin reset levels: chip enable off, restart held
  // ==========================================================================
  localparam logic [CTRL_PIN_W-1:0] CTRL_PIN_RST = 3'h2;
  localparam int                    PIN_CE_N     = 1;
  localparam int                    PIN_RESTART  = 0;
  localparam int                    PIN_READY    = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FRST = 3'b001,
    ST_FREC = 3'b010,
    ST_ADDR = 3'b011,
    ST_READ = 3'b100,
    ST_HAND = 3'b101,
    ST_DONE = 3'b110
  } pfc_state_e;

  typedef struct packed {
    logic flash_hard_rst_n;
    logic flashChipSel_n;
    logic flash_drive_enable_n;
    logic addr_latch_strobe_n;
    logic flash_write_strobe_n;
  } pfc_flash_ctrl_s;

  localparam pfc_flash_ctrl_s CTRL_QUIET = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ===== logic/pfc_pin_sync.sv
`timescale 1ns/1ns
module pfc_pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  // ==========================================================================
  // three stages, a bit moves once stages two and three agree
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
      pinOut   <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      pinOut   <= (stage2_r & stage3_r) | (pinOut & (stage2_r ^ stage3_r));
    end
  end

endmodule

// ===== logic/pfc_loader.sv
`timescale 1ns/1ns
// Contract
// - image comes over a 16-bit flash data path
// - loader generates all clock, address, control itself
// - link clock derived from the internal oscillator
// - link clock never exceeds 40 MHz
// - drive 24-bit word address to flash
// - shared 16-bit bus, flash drives reads
// - ready ignored while configuring, passed to user
// - active-low output enable lets flash drive
// - active-low address-valid strobe latches address
// - active-low write strobe for flash writes
// - active-low hard reset output to flash
// - chip select held low during every access
// - flash starts asynchronous; issue asynchronous access first
// - data sampled after rising link clock edges
// - link clock times every parallel transfer
// - chip enable high, restart low: tristate bus
// - user logic may reuse the flash afterwards
// - chain-enable output may go unused
// - chain-enable driven low once image captured
module pfc_loader
  import pfc_pkg::*;
#(
  parameter int                      IMAGE_WORDS = IMAGE_WORDS_DEF,
  parameter logic [FLASH_ADDR_W-1:0] START_ADDR  = START_ADDR_DEF,
  parameter int                      LINK_DIV    = LINK_DIV_DEF
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    chipEnablePin_n,
  input  wire logic                    config_restart_n,
  input  wire logic                    flashReadyPin,
  input  wire logic [FLASH_DATA_W-1:0] flashDataIn,
  output logic      [FLASH_DATA_W-1:0] flashDataOut,
  output logic                         flashDataOe_n,
  output logic      [FLASH_ADDR_W-1:0] flashAddr,
  output logic                         config_link_clock,
  output pfc_flash_ctrl_s              flashCtrl,
  output logic                         cfgBusOe_n,
  input  wire logic                    imageReady,
  output logic      [FLASH_DATA_W-1:0] imageData,
  output logic                         imageValid,
  output logic                         imageLast,
  output logic                         configDone,
  output logic                         chainEnableOut_n,
  output logic                         userFlashReady
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [CTRL_PIN_W-1:0]   ctrlSync;
  logic [FLASH_DATA_W-1:0] dataSync;
  logic                    enableCfg;
  logic                    tristateReq;

  pfc_pin_sync #(.W(CTRL_PIN_W), .RST_VAL(CTRL_PIN_RST)) uCtrlSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    ({flashReadyPin, chipEnablePin_n, config_restart_n}),
    .pinOut   (ctrlSync)
  );

  // data pins share the same clock; samples are taken only once settled
  pfc_pin_sync #(.W(FLASH_DATA_W)) uDataSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (flashDataIn),
    .pinOut   (dataSync)
  );

  assign enableCfg   = !ctrlSync[PIN_CE_N] && ctrlSync[PIN_RESTART];
  assign tristateReq = ctrlSync[PIN_CE_N] && !ctrlSync[PIN_RESTART];

  // ==========================================================================
  // link clock divider
  // ==========================================================================
  // a 20 MHz core gives at most 10 MHz here, so the 40 MHz cap always holds
  logic [CNT_W-1:0] divCnt_r;
  logic             linkTick;
  logic             linkRise;
  logic             linkClk_r;

  assign linkTick = (divCnt_r == CNT_W'(LINK_DIV - 1));
  assign linkRise = linkTick && !linkClk_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt_r  <= '0;
      linkClk_r <= 1'b0;
    end else begin
      divCnt_r  <= linkTick ? '0 : divCnt_r + 1'b1;
      if (linkTick) begin
        linkClk_r <= !linkClk_r;
      end
    end
  end

  // ==========================================================================
  // sequencer
  // ==========================================================================
  pfc_state_e           state_r;
  pfc_state_e           state_nxt;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic [31:0]          wordCnt_r;
  logic                 accept;
  logic                 lastWord;

  assign accept   = imageValid && imageReady;
  assign lastWord = (wordCnt_r == 32'(IMAGE_WORDS - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (enableCfg) begin
          state_nxt = ST_FRST;
          cnt_nxt   = CNT_W'(RST_PULSE_CYC - 1);
        end
      end
      ST_FRST: begin
        if (cnt_r == '0) begin
          state_nxt = ST_FREC;
          cnt_nxt   = CNT_W'(RST_RECOVER_CYC - 1);
        end
      end
      ST_FREC: begin
        if (cnt_r == '0 && linkRise) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (linkRise) begin
          state_nxt = ST_READ;
          cnt_nxt   = CNT_W'(READ_WAIT_CYC - 1);
        end
      end
      ST_READ: begin
        if (cnt_r == '0 && linkRise) begin
          state_nxt = ST_HAND;
        end
      end
      ST_HAND: begin
        if (accept) begin
          state_nxt = lastWord ? ST_DONE : ST_ADDR;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // a restart or loss of chip enable aborts the load at once
    if (!enableCfg) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ==========================================================================
  // flash strobes, registered from the next state
  // ==========================================================================
  function automatic pfc_flash_ctrl_s ctrlFor(input pfc_state_e st);
    pfc_flash_ctrl_s c;
    c                      = CTRL_QUIET;
    c.flash_hard_rst_n     = (st != ST_FRST);
    c.flashChipSel_n       = !(st == ST_ADDR || st == ST_READ || st == ST_HAND);
    c.flash_drive_enable_n = (st != ST_READ);
    c.addr_latch_strobe_n  = (st != ST_ADDR);
    c.flash_write_strobe_n = 1'b1;
    return c;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flashCtrl  <= CTRL_QUIET;
      cfgBusOe_n <= 1'b1;
    end else begin
      flashCtrl  <= ctrlFor(state_nxt);
      // released when parked, when finished, and when idle before a load
      cfgBusOe_n <= tristateReq || state_nxt == ST_DONE || state_nxt == ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_link_clock <= 1'b0;
    end else begin
      config_link_clock <= linkTick ? !linkClk_r : linkClk_r;
    end
  end

  // the loader never writes, so its data drivers stay off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flashDataOut  <= '0;
      flashDataOe_n <= 1'b1;
    end else begin
      flashDataOut  <= '0;
      flashDataOe_n <= 1'b1;
    end
  end

  // ==========================================================================
  // address and word count
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flashAddr <= START_ADDR;
      wordCnt_r <= '0;
    end else if (state_r == ST_IDLE) begin
      flashAddr <= START_ADDR;
      wordCnt_r <= '0;
    end else if (state_r == ST_HAND && accept && !lastWord) begin
      flashAddr <= flashAddr + 1'b1;
      wordCnt_r <= wordCnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // image stream
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      imageData  <= '0;
      imageValid <= 1'b0;
      imageLast  <= 1'b0;
    end else if (state_r == ST_READ && state_nxt == ST_HAND) begin
      imageData  <= dataSync;
      imageValid <= 1'b1;
      imageLast  <= lastWord;
    end else if (accept || state_nxt == ST_IDLE) begin
      imageValid <= 1'b0;
      imageLast  <= 1'b0;
    end
  end

  // ==========================================================================
  // completion, chain enable, user ready
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      configDone       <= 1'b0;
      chainEnableOut_n <= 1'b1;
      userFlashReady   <= 1'b0;
    end else begin
      configDone       <= (state_nxt == ST_DONE);
      chainEnableOut_n <= !(state_nxt == ST_DONE);
      // the sequencer never looks at ready; it is only passed on
      userFlashReady   <= ctrlSync[PIN_READY];
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_ce_over_access: assert property (
      !flashCtrl.flash_drive_enable_n |-> !flashCtrl.flashChipSel_n)
    else $error("read enable without chip select");
  a_latch_then_read: assert property (
      $rose(flashCtrl.addr_latch_strobe_n) && state_r == ST_READ
      |-> !flashCtrl.flash_drive_enable_n)
    else $error("output enable did not follow address latch");
  a_no_write: assert property (flashCtrl.flash_write_strobe_n && flashDataOe_n)
    else $error("loader drove a write");
  // a restart may legally cut the pulse short, so an abort drops the attempt
  a_hard_reset_len: assert property (disable iff (!rst_n || !enableCfg)
      $fell(flashCtrl.flash_hard_rst_n) |-> !flashCtrl.flash_hard_rst_n [*2])
    else $error("flash reset pulse too short");
  a_tristate_park: assert property (tristateReq |=> cfgBusOe_n)
    else $error("bus not released when parked");
  a_done_chain: assert property (
      configDone |-> !chainEnableOut_n && cfgBusOe_n && flashCtrl.flashChipSel_n)
    else $error("done without chain enable or release");
  a_addr_step: assert property (
      state_r == ST_HAND && accept && !lastWord |=> flashAddr == $past(flashAddr) + 1'b1)
    else $error("address did not step by one");
  a_valid_hold: assert property (
      imageValid && !imageReady && enableCfg |=> imageValid && $stable(imageData))
    else $error("image word dropped under stall");
  // the pin may only move on a divider tick, which bounds its rate
  a_link_rate: assert property ($changed(config_link_clock) |-> $past(linkTick))
    else $error("link clock too fast");
  // an abort may end the read early
  a_read_wait: assert property (disable iff (!rst_n || !enableCfg)
      $fell(flashCtrl.flash_drive_enable_n) |-> !flashCtrl.flash_drive_enable_n [*7])
    else $error("data sampled before access time");

  c_word_taken: cover property (state_r == ST_HAND && accept);
  c_load_done: cover property ($rose(configDone));
  c_abort: cover property (state_r == ST_READ && !enableCfg);
  c_stall: cover property (imageValid && !imageReady [*3]);

endmodule

// ===== dv/pfc_flash_model.sv
`timescale 1ns/1ns
// ============================================================================
// parallel nor flash, asynchronous single-word reads
// ============================================================================
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int ACC_NS = 100
) (
  input  wire logic [FLASH_ADDR_W-1:0] addr,
  input  wire pfc_flash_ctrl_s         ctrl,
  input  wire logic                    stall,
  output logic      [FLASH_DATA_W-1:0] dataOut,
  output logic                         readyOut
);
  logic                    reading;
  logic                    readLate;
  logic [FLASH_DATA_W-1:0] word;
  logic [FLASH_DATA_W-1:0] wordLate;

  // only the low 16 address bits are decoded; higher addresses alias onto that range
  assign word    = addr[15:0] ^ 16'ha5a5;
  // drives only with reset off, selected and output enabled; reads are asynchronous
  assign reading = ctrl.flash_hard_rst_n & ~ctrl.flashChipSel_n & ~ctrl.flash_drive_enable_n;
  // transport delays, so a short gap between reads is not swallowed
  always @(word) wordLate <= #(ACC_NS) word;
  always @(reading) readLate <= #(ACC_NS) reading;
  // a released bus shows the inverse at once, so a stale word never looks valid
  assign dataOut  = (reading && readLate) ? wordLate : ~word;
  assign readyOut = ~stall;
endmodule

// ===== dv/tb_parallel_flash_config_master.sv
`timescale 1ns/1ns
module tb_parallel_flash_config_master
  import pfc_pkg::*;
;
  localparam int                      N_WORDS = 4;
  localparam logic [FLASH_ADDR_W-1:0] BASE    = 24'h00_fffe;

  logic                    core_clk, rst_n, chipEnablePin_n, config_restart_n;
  logic                    imageReady, stall, flashReadyPin, flashDataOe_n;
  logic                    config_link_clock, cfgBusOe_n, imageValid, imageLast;
  logic                    configDone, chainEnableOut_n, userFlashReady;
  logic [FLASH_DATA_W-1:0] flashDataOut, memData, flashBus, imageData;
  logic [FLASH_ADDR_W-1:0] flashAddr;
  pfc_flash_ctrl_s         flashCtrl, ctrlWire;
  int                      n_mismatch, comparisons;
  int                      linkHold, rstLow, wrBad, csBad, latchFalls, oeFalls;
  logic                    prevLink, prevLatch, prevOe;

  // ==========================================================================
  // board: pull-ups hold the strobes quiet while the loader floats them
  // ==========================================================================
  assign ctrlWire = (cfgBusOe_n === 1'b0) ? flashCtrl : CTRL_QUIET;
  assign flashBus = (flashDataOe_n === 1'b0) ? flashDataOut : memData;

  pfc_loader #(.IMAGE_WORDS(N_WORDS), .START_ADDR(BASE), .LINK_DIV(1)) i_pfc_loader (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .chipEnablePin_n  (chipEnablePin_n),
    .config_restart_n (config_restart_n),
    .flashReadyPin    (flashReadyPin),
    .flashDataIn      (flashBus),
    .flashDataOut     (flashDataOut),
    .flashDataOe_n    (flashDataOe_n),
    .flashAddr        (flashAddr),
    .config_link_clock(config_link_clock),
    .flashCtrl        (flashCtrl),
    .cfgBusOe_n       (cfgBusOe_n),
    .imageReady       (imageReady),
    .imageData        (imageData),
    .imageValid       (imageValid),
    .imageLast        (imageLast),
    .configDone       (configDone),
    .chainEnableOut_n (chainEnableOut_n),
    .userFlashReady   (userFlashReady)
  );

  pfc_flash_model i_pfc_flash_model (
    .addr    (flashAddr),
    .ctrl    (ctrlWire),
    .stall   (stall),
    .dataOut (memData),
    .readyOut(flashReadyPin)
  );

  // ==========================================================================
  // pin monitor
  // ==========================================================================
  always @(posedge core_clk) begin
    if (rst_n === 1'b1) begin
      if (config_link_clock === prevLink) linkHold++;
      if (flashCtrl.flash_hard_rst_n === 1'b0) rstLow++;
      if (flashCtrl.flash_write_strobe_n !== 1'b1 || flashDataOe_n !== 1'b1) wrBad++;
      if (flashCtrl.addr_latch_strobe_n === 1'b0 && flashCtrl.flashChipSel_n !== 1'b0) csBad++;
      if (prevLatch === 1'b1 && flashCtrl.addr_latch_strobe_n === 1'b0) latchFalls++;
      if (prevOe === 1'b1 && flashCtrl.flash_drive_enable_n === 1'b0) oeFalls++;
    end
    prevLink  = config_link_clock;
    prevLatch = flashCtrl.addr_latch_strobe_n;
    prevOe    = flashCtrl.flash_drive_enable_n;
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({23'h00_0000, got}, {23'h00_0000, exp});
  endtask

  task automatic clear_mon;
    {linkHold, rstLow, wrBad, csBad, latchFalls, oeFalls} = '0;
  endtask

  // drops the pins long enough for the synchroniser to see it, then enables
  task automatic start_load;
    @(posedge core_clk);
    chipEnablePin_n  <= 1'b1;
    config_restart_n <= 1'b0;
    imageReady       <= 1'b0;
    repeat (PIN_SYNC_LAT + 3) @(posedge core_clk);
    clear_mon();
    chipEnablePin_n  <= 1'b0;
    config_restart_n <= 1'b1;
  endtask

  task automatic collect_image;
    int i;
    int guard;
    i = 0;
    guard = 0;
    while (i < N_WORDS && guard < 3000) begin
      @(negedge core_clk);
      guard++;
      if (imageValid === 1'b1 && imageReady === 1'b1) begin
        check_word({8'h00, imageData}, {8'h00, 16'(BASE + i) ^ 16'ha5a5});
        check_word(flashAddr, 24'(BASE + i));
        check_bit(imageLast, i == N_WORDS - 1);
        i++;
      end
      @(posedge core_clk);
      // consumer stalls in pairs, ready pin wanders meanwhile
      imageReady <= guard[1];
      stall      <= guard[2];
    end
    check_word(24'(i), 24'(N_WORDS));
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic test_reset_state;
    @(negedge core_clk);
    check_word({19'h0_0000, flashCtrl}, {19'h0_0000, CTRL_QUIET});
    check_word(flashAddr, BASE);
    repeat (PIN_SYNC_LAT + 3) @(negedge core_clk);
    check_bit(cfgBusOe_n, 1'b1);
    check_bit(chainEnableOut_n, 1'b1);
    check_bit(imageValid, 1'b0);
  endtask

  task automatic test_full_load;
    start_load();
    collect_image();
    repeat (2) @(negedge core_clk);
    check_bit(configDone, 1'b1);
    check_bit(chainEnableOut_n, 1'b0);
    check_bit(cfgBusOe_n, 1'b1);
    check_word(24'(rstLow), 24'(RST_PULSE_CYC));
    check_word(24'(wrBad), 24'h00_0000);
    check_word({8'h00, flashDataOut}, 24'h00_0000);
    check_word(24'(csBad), 24'h00_0000);
    check_word(24'(latchFalls), 24'(N_WORDS));
    check_word(24'(oeFalls), 24'(N_WORDS));
    check_word(24'(linkHold), 24'h00_0000);
  endtask

  task automatic test_abort_restart;
    int guard;
    start_load();
    guard = 0;
    while (imageValid !== 1'b1 && guard < 500) begin
      @(negedge core_clk);
      guard++;
    end
    check_bit(imageValid, 1'b1);
    @(posedge core_clk);
    chipEnablePin_n  <= 1'b1;
    config_restart_n <= 1'b0;
    repeat (PIN_SYNC_LAT + 3) @(negedge core_clk);
    check_bit(cfgBusOe_n, 1'b1);
    check_bit(imageValid, 1'b0);
    start_load();
    collect_image();
    check_word(24'(rstLow), 24'(RST_PULSE_CYC));
  endtask

  task automatic test_user_ready;
    @(posedge core_clk);
    stall <= 1'b1;
    repeat (PIN_SYNC_LAT + 2) @(negedge core_clk);
    check_bit(userFlashReady, 1'b0);
    @(posedge core_clk);
    stall <= 1'b0;
    repeat (PIN_SYNC_LAT + 2) @(negedge core_clk);
    check_bit(userFlashReady, 1'b1);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // run
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // all loads together take well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch       = 0;
    comparisons      = 0;
    rst_n            = 1'b0;
    chipEnablePin_n  = 1'b1;
    config_restart_n = 1'b0;
    imageReady       = 1'b0;
    stall            = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset_state();
    test_full_load();
    test_abort_restart();
    test_user_ready();
    report_and_stop();
  end
endmodule
